// >>> rtl/zp_defs.svh
// Purpose: constants for the zero-point and auto-zero command interpreter
// Assumes: included by its bare name
// Notes: characters, command codes, reset values and bus offsets
`ifndef ZP_DEFS_SVH
`define ZP_DEFS_SVH

// line characters
`define ZP_CH_CR 8'h0d
`define ZP_CH_LF 8'h0a
`define ZP_CH_SP 8'h20
`define ZP_CH_DOT 8'h2e
`define ZP_CH_0 8'h30
`define ZP_CH_9 8'h39

// command characters
`define ZP_CMD_NITRO 8'h55
`define ZP_CMD_FORCE 8'h75
`define ZP_CMD_KNOWN 8'h58
`define ZP_CMD_FRESH 8'h47
`define ZP_CMD_PARAM 8'h50
`define ZP_CMD_AZ 8'h40
`define ZP_CMD_ALT_SET 8'h53
`define ZP_CMD_ALT_GET 8'h73

// parameter indices of the two background words
`define ZP_IDX_AZ_HI 16'h0008
`define ZP_IDX_AZ_LO 16'h0009
`define ZP_IDX_FR_HI 16'h000a
`define ZP_IDX_FR_LO 16'h000b

// reset values; intervals are in tenths of a day
`define ZP_RST_ALT 16'h2000
`define ZP_RST_AZ_INIT 16'h000a
`define ZP_RST_AZ_REG 16'h0050
`define ZP_RST_BG_HI 8'h01
`define ZP_RST_BG_LO 8'h90
`define ZP_RST_MULT 8'h01
`define ZP_RST_ZERO 16'h0000

// register byte offsets
`define ZP_OFS_CTRL 8'h00
`define ZP_OFS_ZERO 8'h04
`define ZP_OFS_ALT 8'h08
`define ZP_OFS_AZ_INIT 8'h0c
`define ZP_OFS_AZ_REG 8'h10
`define ZP_OFS_BG 8'h14
`define ZP_OFS_STAT 8'h18

`endif

// >>> rtl/zp_pkg.sv
// Purpose: types shared by the command interpreter files
// Assumes: nothing
// Notes: states, number formats and carried groups
package zp_pkg;

  typedef enum logic [3:0] {
    ST_RX, ST_PARSE, ST_EXEC, ST_CMD, ST_SP, ST_CONV, ST_WAIT, ST_DIG,
    ST_ECHO_A, ST_ECHO, ST_CR, ST_LF
  } ctl_state_t;

  // pad5: five digits; tenth: d.d without leading zeros; plain: no leading zeros
  typedef enum logic [1:0] {FM_PAD5, FM_TENTH, FM_PLAIN} fmt_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_beat_t;

  typedef struct packed {
    logic enable;
    logic [15:0] init_tenths;
    logic [15:0] regular_tenths;
  } az_cfg_t;

endpackage : zp_pkg

// >>> rtl/line_mem.sv
// Purpose: character store for one received command line
// Assumes: one write and one read port on the same clock
// Notes: read data come out of a register one cycle after the address
`timescale 1ns/1ps
module line_mem #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // clock
  input wire logic clock,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : line_mem

// >>> rtl/dec5_fmt.sv
// Purpose: binary to five decimal digits by shift and add-three
// Assumes: start is a one-cycle pulse while idle
// Notes: done pulses 16 cycles after start; bcd holds until next start
`timescale 1ns/1ps
module dec5_fmt (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // request
  input wire logic start,
  input wire logic [15:0] value,
  // answer
  output logic done,
  output logic [19:0] bcd
);

  logic [15:0] bin;
  logic [4:0] count;
  logic busy;
  logic [19:0] adj;

  function automatic logic [19:0] add3(input logic [19:0] b);
    logic [19:0] r;
    r = b;
    for (int i = 0; i < 5; i++) begin
      if (r[4*i+:4] > 4'h4) begin
        r[4*i+:4] = r[4*i+:4] + 4'h3;
      end
    end
    return r;
  endfunction : add3

  assign adj = add3(bcd);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      bin <= 16'h0000;
      bcd <= 20'h00000;
      count <= 5'h00;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        bin <= value;
        bcd <= 20'h00000;
        count <= 5'h10;
        busy <= 1'b1;
      end else if (busy) begin
        {bcd, bin} <= {adj[18:0], bin, 1'b0};
        count <= count - 5'h01;
        if (count == 5'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule : dec5_fmt

// >>> rtl/zp_cmd.sv
// Purpose: command interpreter for zero-point, background, auto-zero and altitude
// Assumes: byte streams from and to a UART on the same clock; AHB-Lite slave
// Notes: one line at a time; the receive side stalls while a line is handled
`timescale 1ns/1ps
`include "zp_defs.svh"

// Notes on behaviour
// - act only after CR then LF
// - U: zero from reading, reply zero
// - u: force zero to value, reply zero
// - X: zero from known concentration
// - concentrations scaled by configured multiplier
// - indices 8/9 form auto-zero background word
// - indices 10/11 form fresh-air background word
// - @ two values: store intervals, mirror line
// - reset: enabled, 1.0 and 8.0 days
// - @ 0 disables; two values enable
// - bare @ reports configuration
// - S: store altitude, reply five digits
// - s: report altitude five digits
// - G uses configured fresh-air concentration
module zp_cmd
  import zp_pkg::*;
#(
  parameter int LINE_DEPTH = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // received characters
  input wire rx_beat_t rx,
  output logic rx_ready,
  // transmitted characters
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // raw sensor reading from the measurement path
  input wire logic [15:0] reading,
  // settings
  output logic [15:0] zero_point,
  output logic [15:0] altitude,
  output az_cfg_t az_cfg,
  output logic [15:0] bg_autozero,
  output logic [15:0] bg_fresh,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  localparam int AW = $clog2(LINE_DEPTH);

  function automatic logic [15:0] scale(input logic [15:0] v, input logic [7:0] m);
    return 16'(v * m);
  endfunction : scale

  function automatic logic [15:0] sub_sat(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? 16'(a - b) : 16'h0000;
  endfunction : sub_sat

  ctl_state_t state;
  logic [AW:0] len;
  logic seen_cr;
  logic ovf;
  logic dropped;
  logic [AW:0] rd_addr;
  logic pend;
  logic [AW:0] pidx;
  logic [7:0] mem_rdata;
  logic [7:0] cmd;
  logic [15:0] args [3];
  logic [1:0] nargs;
  logic in_tok;
  logic [7:0] mult;
  logic [7:0] az_hi;
  logic [7:0] az_lo;
  logic [7:0] fr_hi;
  logic [7:0] fr_lo;
  logic [15:0] fld [2];
  logic fi;
  logic two_fld;
  fmt_t fmt;
  logic [2:0] dx;
  logic started;
  logic dot_done;
  logic fmt_done;
  logic [19:0] bcd;
  logic [3:0] digit;
  logic skip;
  logic emit;
  logic [7:0] emit_byte;
  logic tx_free;
  logic rx_take;
  logic is_cr;
  logic is_lf;
  logic store_ch;
  logic is_digit;
  logic [15:0] arg_cur;
  logic [15:0] known_zero;
  logic [15:0] fresh_zero;
  logic bus_rd;
  logic bus_wr;
  logic wr_pend;
  logic [7:0] wr_ofs;
  logic [7:0] rd_ofs;
  logic [31:0] rd_word;
  logic next_reply_go;
  logic next_reply_echo;
  logic reply_ok;
  logic [AW:0] echo_len;

  // receive side
  // next line waits until the reply's final line feed has left
  assign rx_ready = (state == ST_RX) && !tx_valid;
  assign rx_take = rx.valid && rx_ready;
  assign is_cr = (rx.data == `ZP_CH_CR);
  assign is_lf = (rx.data == `ZP_CH_LF);
  assign store_ch = rx_take && !is_cr && !is_lf && (len < (AW+1)'(LINE_DEPTH));

  line_mem #(.DEPTH(LINE_DEPTH), .AW(AW)) u_line (
    .clock(clock),
    .we(store_ch),
    .waddr(len[AW-1:0]),
    .wdata(rx.data),
    .raddr(rd_addr[AW-1:0]),
    .rdata(mem_rdata)
  );

  // argument parsing helpers
  assign is_digit = (mem_rdata >= `ZP_CH_0) && (mem_rdata <= `ZP_CH_9);
  assign arg_cur = args[nargs - 2'd1];
  assign known_zero = sub_sat(reading, scale(args[0], mult));
  assign fresh_zero = sub_sat(reading, bg_fresh);

  // response formatting
  dec5_fmt u_fmt (
    .clock(clock),
    .resetn(resetn),
    .start(state == ST_CONV),
    .value(fld[fi]),
    .done(fmt_done),
    .bcd(bcd)
  );

  assign digit = bcd[4*(3'd4 - dx)+:4];
  assign skip = (state == ST_DIG) && !started && (digit == 4'h0) &&
                (((fmt == FM_TENTH) && (dx < 3'd3)) || ((fmt == FM_PLAIN) && (dx < 3'd4)));
  assign tx_free = !tx_valid || tx_ready;
  assign emit = tx_free && !skip && ((state == ST_CMD) || (state == ST_SP) ||
                (state == ST_DIG) || (state == ST_ECHO) || (state == ST_CR) ||
                (state == ST_LF));
  assign emit_byte = (state == ST_CMD) ? cmd :
                     (state == ST_SP) ? `ZP_CH_SP :
                     (state == ST_ECHO) ? mem_rdata :
                     (state == ST_CR) ? `ZP_CH_CR :
                     (state == ST_LF) ? `ZP_CH_LF :
                     ((fmt == FM_TENTH) && (dx == 3'd4) && !dot_done) ? `ZP_CH_DOT :
                     (`ZP_CH_0 | {4'h0, digit});

  always_ff @(posedge clock) begin
    if (!resetn) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else if (emit) begin
      tx_valid <= 1'b1;
      tx_data <= emit_byte;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // line collection and parsing
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= ST_RX;
      len <= '0;
      seen_cr <= 1'b0;
      ovf <= 1'b0;
      dropped <= 1'b0;
      rd_addr <= '0;
      pend <= 1'b0;
      pidx <= '0;
      cmd <= 8'h00;
      args <= '{default: 16'h0000};
      nargs <= 2'd0;
      in_tok <= 1'b0;
    end else begin
      unique case (state)
        ST_RX: begin
          if (rx_take) begin
            if (is_cr) begin
              seen_cr <= 1'b1;
            end else if (is_lf && seen_cr) begin
              seen_cr <= 1'b0;
              len <= '0;
              ovf <= 1'b0;
              dropped <= ovf;
              if (!ovf && (len != '0)) begin
                len <= len;
                state <= ST_PARSE;
                rd_addr <= '0;
                pend <= 1'b0;
                nargs <= 2'd0;
                in_tok <= 1'b0;
                args <= '{default: 16'h0000};
              end
            end else if (!is_lf) begin
              seen_cr <= 1'b0;
              if (store_ch) begin
                len <= len + 1'b1;
              end else begin
                ovf <= 1'b1;
              end
            end
          end
        end
        ST_PARSE: begin
          pend <= (rd_addr < len);
          pidx <= rd_addr;
          if (rd_addr < len) begin
            rd_addr <= rd_addr + 1'b1;
          end
          if (pend) begin
            if (pidx == '0) begin
              cmd <= mem_rdata;
            end else if (mem_rdata == `ZP_CH_SP) begin
              in_tok <= 1'b0;
            end else if (is_digit) begin
              if (!in_tok && (nargs != 2'd3)) begin
                nargs <= nargs + 2'd1;
                args[nargs] <= {8'h00, mem_rdata - `ZP_CH_0};
                in_tok <= 1'b1;
              end else if (in_tok) begin
                args[nargs - 2'd1] <= 16'(arg_cur * 10) + {8'h00, mem_rdata - `ZP_CH_0};
              end
            end
          end else if (rd_addr >= len) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: state <= ST_RX;
        default: ;
      endcase
      if (next_reply_go) begin
        state <= next_reply_echo ? ST_ECHO_A : ST_CMD;
      end
      if (state == ST_EXEC) begin
        len <= '0;
      end
      unique case (state)
        ST_CMD: if (emit) state <= ST_SP;
        ST_SP: if (emit) state <= ST_CONV;
        ST_CONV: state <= ST_WAIT;
        ST_WAIT: if (fmt_done) state <= ST_DIG;
        ST_DIG: if ((emit || skip) && (dx == 3'd4) && !((fmt == FM_TENTH) && !dot_done)) begin
          state <= (two_fld && !fi) ? ST_SP : ST_CR;
        end
        ST_ECHO_A: state <= ST_ECHO;
        ST_ECHO: if (emit) begin
          rd_addr <= rd_addr + 1'b1;
          state <= (rd_addr + 1'b1 >= echo_len) ? ST_CR : ST_ECHO_A;
        end
        ST_CR: if (emit) state <= ST_LF;
        ST_LF: if (emit) state <= ST_RX;
        default: ;
      endcase
      if (next_reply_go && next_reply_echo) begin
        rd_addr <= '0;
      end
    end
  end

  // command execution
  assign next_reply_go = (state == ST_EXEC) && reply_ok;

  always_comb begin
    reply_ok = 1'b1;
    next_reply_echo = 1'b0;
    unique case (cmd)
      `ZP_CMD_NITRO, `ZP_CMD_FORCE, `ZP_CMD_KNOWN, `ZP_CMD_FRESH,
      `ZP_CMD_ALT_SET, `ZP_CMD_ALT_GET: ;
      `ZP_CMD_PARAM: reply_ok = (args[0] >= `ZP_IDX_AZ_HI) && (args[0] <= `ZP_IDX_FR_LO);
      `ZP_CMD_AZ: begin
        next_reply_echo = (nargs != 2'd0);
        reply_ok = (nargs == 2'd0) || (nargs == 2'd2) || ((nargs == 2'd1) && (args[0] == 16'h0000));
      end
      default: reply_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      zero_point <= `ZP_RST_ZERO;
      altitude <= `ZP_RST_ALT;
      az_cfg <= '{enable: 1'b1, init_tenths: `ZP_RST_AZ_INIT, regular_tenths: `ZP_RST_AZ_REG};
      az_hi <= `ZP_RST_BG_HI;
      az_lo <= `ZP_RST_BG_LO;
      fr_hi <= `ZP_RST_BG_HI;
      fr_lo <= `ZP_RST_BG_LO;
      fld <= '{default: 16'h0000};
      two_fld <= 1'b0;
      fmt <= FM_PAD5;
      echo_len <= '0;
    end else if (state == ST_EXEC) begin
      two_fld <= 1'b0;
      fmt <= FM_PAD5;
      echo_len <= len;
      unique case (cmd)
        `ZP_CMD_NITRO: begin
          zero_point <= reading;
          fld[0] <= reading;
        end
        `ZP_CMD_FORCE: begin
          zero_point <= args[0];
          fld[0] <= args[0];
        end
        `ZP_CMD_KNOWN: begin
          zero_point <= known_zero;
          fld[0] <= known_zero;
        end
        `ZP_CMD_FRESH: begin
          zero_point <= fresh_zero;
          fld[0] <= fresh_zero;
        end
        `ZP_CMD_PARAM: begin
          two_fld <= 1'b1;
          fld[0] <= args[0];
          fld[1] <= {8'h00, args[1][7:0]};
          if (args[0] == `ZP_IDX_AZ_HI) az_hi <= args[1][7:0];
          if (args[0] == `ZP_IDX_AZ_LO) az_lo <= args[1][7:0];
          if (args[0] == `ZP_IDX_FR_HI) fr_hi <= args[1][7:0];
          if (args[0] == `ZP_IDX_FR_LO) fr_lo <= args[1][7:0];
        end
        `ZP_CMD_AZ: begin
          if (nargs == 2'd2) begin
            az_cfg <= '{enable: 1'b1, init_tenths: args[0], regular_tenths: args[1]};
          end else if ((nargs == 2'd1) && (args[0] == 16'h0000)) begin
            az_cfg.enable <= 1'b0;
          end else if (nargs == 2'd0) begin
            two_fld <= az_cfg.enable;
            fmt <= az_cfg.enable ? FM_TENTH : FM_PLAIN;
            fld[0] <= az_cfg.enable ? az_cfg.init_tenths : 16'h0000;
            fld[1] <= az_cfg.regular_tenths;
          end
        end
        `ZP_CMD_ALT_SET: begin
          altitude <= args[0];
          fld[0] <= args[0];
        end
        `ZP_CMD_ALT_GET: fld[0] <= altitude;
        default: ;
      endcase
    end
  end

  // background words, scaled before use
  always_ff @(posedge clock) begin
    if (!resetn) begin
      bg_autozero <= 16'h0000;
      bg_fresh <= 16'h0000;
    end else begin
      bg_autozero <= scale({az_hi, az_lo}, mult);
      bg_fresh <= scale({fr_hi, fr_lo}, mult);
    end
  end

  // digit sequencing
  always_ff @(posedge clock) begin
    if (!resetn) begin
      fi <= 1'b0;
      dx <= 3'd0;
      started <= 1'b0;
      dot_done <= 1'b0;
    end else begin
      if (state == ST_EXEC) begin
        fi <= 1'b0;
      end
      if (state == ST_CONV) begin
        dx <= 3'd0;
        started <= 1'b0;
        dot_done <= 1'b0;
      end
      if ((state == ST_DIG) && (emit || skip)) begin
        if ((fmt == FM_TENTH) && (dx == 3'd4) && !dot_done) begin
          dot_done <= 1'b1;
        end else begin
          started <= started | !skip;
          if (dx == 3'd4) begin
            fi <= 1'b1;
          end else begin
            dx <= dx + 3'd1;
          end
        end
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bus_rd = hsel && htrans[1] && !hwrite && hready;
  assign bus_wr = hsel && htrans[1] && hwrite && hready;
  assign rd_ofs = haddr[7:0];
  assign rd_word = (rd_ofs == `ZP_OFS_CTRL) ? {23'h000000, az_cfg.enable, mult} :
                   (rd_ofs == `ZP_OFS_ZERO) ? {16'h0000, zero_point} :
                   (rd_ofs == `ZP_OFS_ALT) ? {16'h0000, altitude} :
                   (rd_ofs == `ZP_OFS_AZ_INIT) ? {16'h0000, az_cfg.init_tenths} :
                   (rd_ofs == `ZP_OFS_AZ_REG) ? {16'h0000, az_cfg.regular_tenths} :
                   (rd_ofs == `ZP_OFS_BG) ? {bg_fresh, bg_autozero} :
                   (rd_ofs == `ZP_OFS_STAT) ? {30'h00000000, dropped, state != ST_RX} :
                   32'h00000000;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
      mult <= `ZP_RST_MULT;
    end else begin
      if (bus_rd) begin
        hrdata <= (haddr[31:8] == 24'h000000) ? rd_word : 32'h00000000;
      end
      wr_pend <= bus_wr && (haddr[31:8] == 24'h000000);
      wr_ofs <= rd_ofs;
      if (wr_pend && (wr_ofs == `ZP_OFS_CTRL)) begin
        mult <= hwdata[7:0];
      end
    end
  end

endmodule : zp_cmd

// >>> tb/zp_cmd_assertions.sv
// Purpose: port checks for the command interpreter
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every zp_cmd instance
`timescale 1ns/1ps
module zp_cmd_checker
  import zp_pkg::*;
#(
  parameter int LINE_DEPTH = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // line link
  input wire rx_beat_t rx,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  // settings
  input wire logic [15:0] zero_point,
  input wire logic [15:0] altitude,
  input wire az_cfg_t az_cfg,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence cr_out; tx_valid && tx_ready && tx_data == 8'h0d; endsequence
  sequence lf_out; tx_valid && tx_ready && tx_data == 8'h0a; endsequence
  sequence rd_at(logic [31:0] a); hsel && htrans[1] && hready && !hwrite && haddr == a;
  endsequence
  chk_act_after_lf: assert property ($fell(rx_ready) |-> $past(rx.valid && rx.data == 8'h0a))
    else $error("line closed without a line feed");
  chk_cr_then_lf: assert property (cr_out |-> ##[1:4] (tx_valid && tx_data == 8'h0a))
    else $error("reply carriage return not followed by line feed");
  chk_reply_busy: assert property (tx_valid |-> !rx_ready)
    else $error("receiving while replying");
  chk_update_busy: assert property ((!$stable(altitude) || !$stable(zero_point)
    || !$stable(az_cfg)) |-> !rx_ready) else $error("setting changed while collecting");
  chk_reply_reopen: assert property (lf_out |-> ##[1:3] rx_ready)
    else $error("receiver not reopened after reply");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply character dropped while stalled");
  chk_reset_vals: assert property ($rose(resetn) |-> altitude == 16'h2000 && zero_point == 0
    && az_cfg == {1'b1, 16'h000a, 16'h0050}) else $error("bad reset settings");
  chk_alt_read: assert property (rd_at(32'h8) |=> hrdata == {16'h0000, $past(altitude)})
    else $error("altitude read mismatch");
  chk_enable_read: assert property (rd_at(32'h0) |=> hrdata[8] == $past(az_cfg.enable))
    else $error("enable bit read mismatch");
endmodule : zp_cmd_checker

bind zp_cmd zp_cmd_checker #(.LINE_DEPTH(LINE_DEPTH)) chk_inst (
  .clock(clock), .resetn(resetn), .rx(rx), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .zero_point(zero_point), .altitude(altitude),
  .az_cfg(az_cfg), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata)
);

// >>> tb/zp_host_model.sv
// Purpose: host controller sending command lines and taking replies
// Assumes: byte link on the device clock
// Notes: slow stalls reply acceptance to one cycle in four
`timescale 1ns/1ps
module zp_host_model
  import zp_pkg::*;
(
  // clock
  input wire logic clock,
  // line to device
  output rx_beat_t rx,
  input wire logic rx_ready,
  // replies
  input wire logic slow,
  output logic tx_ready
);
  logic [1:0] tick = 2'b00;
  initial rx = '0;
  always @(posedge clock) tick <= tick + 2'b01;
  assign tx_ready = !slow || tick == 2'b11;
  task automatic put(input logic [7:0] b);
    @(posedge clock);
    rx <= '{valid: 1'b1, data: b};
    do @(posedge clock); while (rx_ready !== 1'b1);
    // released line shows the inverse of the last byte
    rx <= '{valid: 1'b0, data: ~b};
  endtask : put
  task automatic send_line(input string s);
    foreach (s[i]) put(s[i]);
    put(8'h0d);
    put(8'h0a);
  endtask : send_line
endmodule : zp_host_model

// >>> tb/zp_cmd_tb.sv
// Purpose: self-checking bench for the command interpreter
// Assumes: host model on the line link, bench as bus master
// Notes: reply characters are compared against a queue of notes
`timescale 1ns/1ps
module zp_cmd_tb;
  import zp_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic slow = 1'b0;
  logic [15:0] reading = 16'h0000;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  rx_beat_t rx;
  logic rx_ready;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_ready;
  logic [7:0] exp_q[$];
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'hde0b;
  always #2 clock = ~clock;
  zp_cmd zp_cmd_inst (
    .clock(clock), .resetn(resetn), .rx(rx), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .reading(reading), .zero_point(),
    .altitude(), .az_cfg(), .bg_autozero(), .bg_fresh(), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
  );
  zp_host_model zp_host_model_inst (
    .clock(clock), .rx(rx), .rx_ready(rx_ready), .slow(slow), .tx_ready(tx_ready)
  );
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // reply watcher: a character with no note pending is a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      print_verdict();
    end
    if (resetn && tx_valid && tx_ready) begin
      if (exp_q.size() == 0) check({24'h0, tx_data}, 32'h100);
      else check({24'h0, tx_data}, {24'h0, exp_q.pop_front()});
    end
  end
  task automatic cmd(input string s, input string r);
    foreach (r[i]) exp_q.push_back(r[i]);
    if (r.len() > 0) exp_q.push_back(8'h0d);
    if (r.len() > 0) exp_q.push_back(8'h0a);
    zp_host_model_inst.send_line(s);
    while (exp_q.size() != 0) @(posedge clock);
    while (rx_ready !== 1'b1) @(posedge clock);
  endtask : cmd
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb
  task automatic ahb_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    check(q, e);
    check({31'h0, hresp}, 32'h0);
  endtask : ahb_rd
  task automatic set_reading(input logic [15:0] v);
    @(posedge clock);
    reading <= v;
  endtask : set_reading
  initial begin
    logic [15:0] v;
    logic [15:0] c;
    logic [15:0] alt;
    logic [31:0] q;
    int a;
    int f;
    int pv[4];
    int pi[4];
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    ahb_rd(8'h08, 32'h2000);
    ahb_rd(8'h0c, 32'h000a);
    ahb_rd(8'h10, 32'h0050);
    ahb_rd(8'h00, 32'h0101);
    ahb_rd(8'h14, 32'h01900190);
    ahb_rd(8'h40, 32'h0);
    cmd("s", "s 08192");
    cmd("@", "@ 1.0 8.0");
    for (int k = 0; k < 3; k++) begin
      seed = lfsr_next(seed);
      v = (k == 0) ? 16'hffff : seed[15:0];
      slow <= k[0];
      cmd($sformatf("S %0d", v), $sformatf("S %05d", v));
      cmd("s", $sformatf("s %05d", v));
      cmd($sformatf("u %0d", ~v), $sformatf("u %05d", ~v));
      set_reading(v);
      cmd("U", $sformatf("U %05d", v));
    end
    alt = v;
    ahb(1'b1, 8'h00, 32'h2, q);
    ahb_rd(8'h00, 32'h0102);
    v = {1'b1, seed[30:16]};
    c = {4'h0, seed[11:0]};
    set_reading(v);
    cmd($sformatf("X %0d", c), $sformatf("X %05d", v - (c << 1)));
    set_reading(16'h0010);
    cmd("X 100", "X 00000");
    a = 773;
    f = 2000;
    pi = '{8, 9, 10, 11};
    pv = '{a / 256, a - 256 * (a / 256), f / 256, f - 256 * (f / 256)};
    foreach (pi[j]) cmd($sformatf("P %0d %0d", pi[j], pv[j]),
      $sformatf("P %05d %05d", pi[j], pv[j]));
    ahb_rd(8'h14, (f * 2) * 65536 + a * 2);
    set_reading(v);
    cmd("G", $sformatf("G %05d", v - 16'd4000));
    cmd("@ 0", "@ 0");
    cmd("@", "@ 0");
    ahb_rd(8'h00, 32'h0002);
    cmd("@ 2.5 7.0", "@ 2.5 7.0");
    cmd("@", "@ 2.5 7.0");
    ahb_rd(8'h0c, 32'd25);
    ahb_rd(8'h10, 32'd70);
    ahb_rd(8'h00, 32'h0102);
    cmd("Z 1", "");
    cmd("", "");
    cmd("S 123456789012345678901234567890123456", "");
    ahb_rd(8'h18, 32'h0002);
    cmd("s", $sformatf("s %05d", alt));
    print_verdict();
  end
endmodule : zp_cmd_tb
